// [cacc_pin_model.sv]
// cacc_pin_model: outside world on the three module pins
// assumes: the bench asks for capture levels on level_i; the block drives
// a pin wherever its output enable is low
`timescale 1ns/1ns
module cacc_pin_model (
    // clock
    input  wire logic                          sys_clk_i,
    // requested external levels
    input  wire logic [cacc_pkg::NUM_MOD-1:0]  level_i,
    // block side of the pins
    input  wire logic [cacc_pkg::NUM_MOD-1:0]  pin_o_i,
    input  wire logic [cacc_pkg::NUM_MOD-1:0]  pin_oe_n_i,
    output logic      [cacc_pkg::NUM_MOD-1:0]  pin_wire_o
);
    logic [cacc_pkg::NUM_MOD-1:0]  ext_q;   // level the outside source drives
    int                            hold_q [cacc_pkg::NUM_MOD]; // cycles since last change

    initial begin
        ext_q = '0;
        for (int i = 0; i < cacc_pkg::NUM_MOD; i++) hold_q[i] = 2;
    end

    ////////////////////////////////////////////////////////////////////////////
    // a request is sampled only once the old level stood three clocks, so a short glitch
    // from the bench reaches the capture logic stretched to three clocks, or is lost inside that hold
    always @(posedge sys_clk_i) begin
        for (int i = 0; i < cacc_pkg::NUM_MOD; i++) begin
            if (hold_q[i] < 2) begin
                hold_q[i] <= hold_q[i] + 1;
            end else if (level_i[i] != ext_q[i]) begin
                ext_q[i]  <= level_i[i];
                hold_q[i] <= 0;
            end
        end
    end

    // wire level: the block wins while it drives, else the outside source
    always_comb begin
        for (int i = 0; i < cacc_pkg::NUM_MOD; i++)
            pin_wire_o[i] = pin_oe_n_i[i] ? ext_q[i] : pin_o_i[i];
    end
endmodule

// [cacc_pkg.sv]
// cacc_pkg: constants, types and mode codes for the capture/compare modules
// assumes: a shared 16-bit counter timebase and a byte-wide register port
package cacc_pkg;
    // number of modules sharing the timebase
    localparam int NUM_MOD = 3;
    // module mode register bit positions
    localparam int B_WIDE = 7;
    localparam int B_CMP  = 6;
    localparam int B_RISE = 5;
    localparam int B_FALL = 4;
    localparam int B_MAT  = 3;
    localparam int B_TOG  = 2;
    localparam int B_PWM  = 1;
    localparam int B_IRQ  = 0;
    // pwm configuration register bit positions (cycle length in 1:0)
    localparam int C_VIEW = 7;
    localparam int C_OVIE = 5;
    localparam int C_OVF  = 4;
    // register addresses: module i sits at i*MOD_STRIDE plus offset
    localparam logic [3:0] MOD_STRIDE = 4'h4;
    localparam logic [3:0] A_MODE     = 4'h0;
    localparam logic [3:0] A_CMPL     = 4'h1;
    localparam logic [3:0] A_CMPH     = 4'h2;
    localparam logic [3:0] A_PWMCFG   = 4'hC;
    localparam logic [3:0] A_FLAGS    = 4'hD;
    // reset values
    localparam logic [7:0]  MODE_RST = 8'h00;
    localparam logic [15:0] CMP_RST  = 16'h0000;
    localparam logic [1:0]  CLS_RST  = 2'h0;
    // operating modes, one-hot
    typedef enum logic [6:0] {
        M_IDLE  = 7'b0000001,
        M_CAP   = 7'b0000010,
        M_TIMER = 7'b0000100,
        M_HSO   = 7'b0001000,
        M_FREQ  = 7'b0010000,
        M_PWM_ENABLE  = 7'b0100000,
        M_PWM16 = 7'b1000000
    } cacc_mode_e;
    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } cacc_req_s;
    // all state of the block
    typedef struct packed {
        logic [NUM_MOD-1:0][7:0]  mode;
        logic [NUM_MOD-1:0][15:0] cmp;
        logic [NUM_MOD-1:0][15:0] rld;
        logic [NUM_MOD-1:0]       flag;
        logic [NUM_MOD-1:0]       pin;
        logic [NUM_MOD-1:0]       sy1;
        logic [NUM_MOD-1:0]       sy2;
        logic [NUM_MOD-1:0]       sy3;
        logic                     view;
        logic                     ovie;
        logic                     ovf;
        logic [1:0]               cls;
        logic [7:0]               rdata;
    } cacc_state_s;
endpackage

// [cacc_top.sv]
// cacc_top: three capture/compare modules on one shared counter timebase
// assumes: counter_i and cnt_new_i come from the counter logic on sys_clk_i;
// module pins arrive asynchronously and are synchronised here
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
module cacc_top (
    // clock, reset, enable
    input  wire logic                          sys_clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          ce_i,
    // shared timebase
    input  wire logic [15:0]                   counter_i,
    input  wire logic                          cnt_new_i,
    // register port
    input  wire cacc_pkg::cacc_req_s           sfr_req_i,
    output logic      [7:0]                    sfr_rdata_o,
    // module pins
    input  wire logic [cacc_pkg::NUM_MOD-1:0]  module_pin_i,
    output logic      [cacc_pkg::NUM_MOD-1:0]  module_pin_o,
    output logic      [cacc_pkg::NUM_MOD-1:0]  module_pin_oe_n_o,
    // interrupt requests and flags
    output logic      [cacc_pkg::NUM_MOD-1:0]  module_event_flag_o,
    output logic      [cacc_pkg::NUM_MOD-1:0]  module_irq_o,
    output logic                               overflow_irq_o
);

    //////////////////////////////////////////////////////////////////////////
    // helpers

    // decode a mode register into an operating mode
    function automatic cacc_pkg::cacc_mode_e mode_of(input logic [7:0] m);
        cacc_pkg::cacc_mode_e r;
        r = cacc_pkg::M_IDLE;
        if ((m[cacc_pkg::B_RISE] | m[cacc_pkg::B_FALL]) && (m[3:1] == 3'h0)) begin
            r = cacc_pkg::M_CAP;
        end else if (m[cacc_pkg::B_PWM] && m[cacc_pkg::B_TOG]) begin
            r = cacc_pkg::M_FREQ;
        end else if (m[cacc_pkg::B_PWM]) begin
            r = m[cacc_pkg::B_WIDE] ? cacc_pkg::M_PWM16 : cacc_pkg::M_PWM_ENABLE;
        end else if (m[cacc_pkg::B_TOG]) begin
            r = cacc_pkg::M_HSO;
        end else if (m[cacc_pkg::B_MAT]) begin
            r = cacc_pkg::M_TIMER;
        end
        return r;
    endfunction

    // mask of the low 8..11 counter bits for a cycle length code
    function automatic logic [15:0] len_mask(input logic [1:0] c);
        return 16'(16'h07FF >> (2'h3 - c));
    endfunction

    // register address of a module's register
    function automatic logic [3:0] mod_addr(input int i, input logic [3:0] off);
        return 4'(i * cacc_pkg::MOD_STRIDE) + off;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // state

    cacc_pkg::cacc_state_s s_q;     // registered state
    cacc_pkg::cacc_state_s s_d;     // next state
    logic                  ovf_n;   // overflow out of the selected bit
    logic                  ovf_16;  // full 16-bit overflow
    localparam int NUM_CAP_W = cacc_pkg::NUM_MOD;
    logic [NUM_CAP_W-1:0]  cap_ev;  // capture event per module

    // overflow is seen when the counter has just wrapped its low bits to zero
    assign ovf_n  = cnt_new_i && ((counter_i & len_mask(s_q.cls)) == 16'h0000);
    assign ovf_16 = cnt_new_i && (counter_i == 16'h0000);

    //////////////////////////////////////////////////////////////////////////
    // next-state logic: software accesses first, hardware events after,
    // so that a hardware set always wins over a software clear
    always_comb begin
        cacc_pkg::cacc_mode_e m;
        logic                 en;
        logic                 full;
        logic                 hit;
        logic [15:0]          nv;
        m    = cacc_pkg::M_IDLE;
        en   = 1'b0;
        full = 1'b0;
        hit  = 1'b0;
        nv   = 16'h0000;
        s_d  = s_q;
        cap_ev = '0;
        // pin synchronisers; the second and third stages feed the edge logic
        s_d.sy1 = module_pin_i;
        s_d.sy2 = s_q.sy1;
        s_d.sy3 = s_q.sy2;
        // shared registers
        if (sfr_req_i.wr && sfr_req_i.addr == cacc_pkg::A_PWMCFG) begin
            s_d.view = sfr_req_i.wdata[cacc_pkg::C_VIEW];
            s_d.ovie = sfr_req_i.wdata[cacc_pkg::C_OVIE];
            s_d.ovf  = s_q.ovf & sfr_req_i.wdata[cacc_pkg::C_OVF];
            s_d.cls  = sfr_req_i.wdata[1:0];
        end
        if (sfr_req_i.wr && sfr_req_i.addr == cacc_pkg::A_FLAGS) begin
            // writing 0 clears a flag, writing 1 leaves it
            s_d.flag = s_q.flag & sfr_req_i.wdata[cacc_pkg::NUM_MOD-1:0];
        end
        // read data, unmapped addresses read zero
        if (sfr_req_i.rd) begin
            s_d.rdata = 8'h00;
            case (sfr_req_i.addr)
                cacc_pkg::A_PWMCFG: s_d.rdata = {s_q.view, 1'b0, s_q.ovie, s_q.ovf, 2'h0, s_q.cls};
                cacc_pkg::A_FLAGS:  s_d.rdata = 8'(s_q.flag);
                default:            s_d.rdata = 8'h00;
            endcase
        end
        for (int i = 0; i < cacc_pkg::NUM_MOD; i++) begin
            // software side of module i
            if (sfr_req_i.rd && sfr_req_i.addr == mod_addr(i, cacc_pkg::A_MODE)) begin
                s_d.rdata = s_q.mode[i];
            end
            if (sfr_req_i.rd && sfr_req_i.addr == mod_addr(i, cacc_pkg::A_CMPL)) begin
                s_d.rdata = s_q.view ? s_q.rld[i][7:0] : s_q.cmp[i][7:0];
            end
            if (sfr_req_i.rd && sfr_req_i.addr == mod_addr(i, cacc_pkg::A_CMPH)) begin
                s_d.rdata = s_q.view ? s_q.rld[i][15:8] : s_q.cmp[i][15:8];
            end
            if (sfr_req_i.wr && sfr_req_i.addr == mod_addr(i, cacc_pkg::A_MODE)) begin
                s_d.mode[i] = sfr_req_i.wdata;
            end
            if (sfr_req_i.wr && sfr_req_i.addr == mod_addr(i, cacc_pkg::A_CMPL)) begin
                if (s_q.view) begin
                    s_d.rld[i][7:0] = sfr_req_i.wdata;
                end else begin
                    s_d.cmp[i][7:0] = sfr_req_i.wdata;
                end
                s_d.mode[i][cacc_pkg::B_CMP] = 1'b0;
            end
            if (sfr_req_i.wr && sfr_req_i.addr == mod_addr(i, cacc_pkg::A_CMPH)) begin
                if (s_q.view) begin
                    s_d.rld[i][15:8] = sfr_req_i.wdata;
                end else begin
                    s_d.cmp[i][15:8] = sfr_req_i.wdata;
                end
                s_d.mode[i][cacc_pkg::B_CMP] = 1'b1;
            end
            // hardware side of module i, all on the shared timebase
            m    = mode_of(s_q.mode[i]);
            en   = s_q.mode[i][cacc_pkg::B_CMP];
            full = cnt_new_i && (counter_i == s_q.cmp[i]);
            case (m)
                cacc_pkg::M_CAP: begin
                    cap_ev[i] = (s_q.mode[i][cacc_pkg::B_RISE] && s_q.sy2[i] && !s_q.sy3[i]) ||
                                (s_q.mode[i][cacc_pkg::B_FALL] && !s_q.sy2[i] && s_q.sy3[i]);
                    if (cap_ev[i]) begin
                        s_d.cmp[i]  = counter_i;
                        s_d.flag[i] = 1'b1;
                    end
                end
                cacc_pkg::M_TIMER: begin
                    if (en && full) begin
                        s_d.flag[i] = 1'b1;
                    end
                end
                cacc_pkg::M_HSO: begin
                    // comparator off: the pin keeps its level
                    if (en && full) begin
                        s_d.pin[i] = !s_q.pin[i];
                        if (s_q.mode[i][cacc_pkg::B_MAT]) begin
                            s_d.flag[i] = 1'b1;
                        end
                    end
                end
                cacc_pkg::M_FREQ: begin
                    // adding a zero high byte brings the next match 256 clocks on
                    if (en && cnt_new_i && counter_i[7:0] == s_q.cmp[i][7:0]) begin
                        s_d.pin[i]      = !s_q.pin[i];
                        s_d.cmp[i][7:0] = s_q.cmp[i][7:0] + s_q.cmp[i][15:8];
                    end
                    if (s_q.mode[i][cacc_pkg::B_MAT] && full) begin
                        s_d.flag[i] = 1'b1;
                    end
                end
                cacc_pkg::M_PWM_ENABLE, cacc_pkg::M_PWM16: begin
                    // compare against the value reloaded at this overflow (16-bit: cmp itself), so a
                    // zero duty word still gives a full-high cycle
                    if (m == cacc_pkg::M_PWM16) begin
                        nv  = s_q.cmp[i];
                        hit = full;
                        s_d.pin[i] = ovf_16 ? 1'b0 : s_q.pin[i];
                    end else begin
                        if (s_q.cls == 2'h0) begin
                            nv = ovf_n ? {s_q.cmp[i][15:8], s_q.cmp[i][15:8]} : s_q.cmp[i];
                        end else begin
                            nv = ovf_n ? s_q.rld[i] : s_q.cmp[i];
                        end
                        hit = cnt_new_i && ((counter_i & len_mask(s_q.cls)) ==
                                            (nv & len_mask(s_q.cls)));
                        s_d.pin[i] = ovf_n ? 1'b0 : s_q.pin[i];
                        // reload only at overflow, so a software byte write lands otherwise
                        if (ovf_n) begin
                            s_d.cmp[i] = nv;
                        end
                    end
                    if (hit) begin
                        s_d.pin[i] = 1'b1;
                        if (s_q.mode[i][cacc_pkg::B_MAT]) begin
                            s_d.flag[i] = 1'b1;
                        end
                    end
                    if (!en) begin
                        s_d.pin[i] = 1'b0;
                    end
                end
                default: begin
                    // idle: pin keeps its level
                end
            endcase
        end
        // intermediate overflow, set wins over clear
        if (ovf_n) begin
            s_d.ovf = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // state register, frozen while ce_i is low
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q       <= '0;
            s_q.mode  <= {cacc_pkg::NUM_MOD{cacc_pkg::MODE_RST}};
            s_q.cmp   <= {cacc_pkg::NUM_MOD{cacc_pkg::CMP_RST}};
            s_q.rld   <= {cacc_pkg::NUM_MOD{cacc_pkg::CMP_RST}};
            s_q.cls   <= cacc_pkg::CLS_RST;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        for (int i = 0; i < cacc_pkg::NUM_MOD; i++) begin
            // capture and idle modules leave the pin to the outside
            module_pin_oe_n_o[i] = (mode_of(s_q.mode[i]) == cacc_pkg::M_CAP) ||
                                   (mode_of(s_q.mode[i]) == cacc_pkg::M_IDLE);
            module_irq_o[i] = s_q.flag[i] && s_q.mode[i][cacc_pkg::B_IRQ];
        end
    end
    assign sfr_rdata_o         = s_q.rdata;
    assign module_pin_o        = s_q.pin;
    assign module_event_flag_o = s_q.flag;
    assign overflow_irq_o      = s_q.ovf && s_q.ovie;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    a_flag_sticky: assert property (
        s_q.flag[0] && !(sfr_req_i.wr && sfr_req_i.addr == cacc_pkg::A_FLAGS) |=> s_q.flag[0])
        else $error("event flag dropped without a clear");
    a_irq_request: assert property (
        $rose(s_q.flag[0]) && s_q.mode[0][0] |-> module_irq_o[0])
        else $error("flag with enable raised no interrupt");
    a_low_clears: assert property (
        ce_i && sfr_req_i.wr && sfr_req_i.addr == cacc_pkg::A_CMPL |=> !s_q.mode[0][6])
        else $error("low byte write left comparator on");
    a_high_sets: assert property (
        ce_i && sfr_req_i.wr && sfr_req_i.addr == cacc_pkg::A_CMPH |=> s_q.mode[0][6])
        else $error("high byte write left comparator off");
    a_capture_load: assert property (
        ce_i && cap_ev[1] |=> s_q.cmp[1] == $past(counter_i) && s_q.flag[1])
        else $error("capture did not load counter and flag");
    a_timer_flag: assert property (
        ce_i && mode_of(s_q.mode[0]) == cacc_pkg::M_TIMER && s_q.mode[0][6] && cnt_new_i &&
        counter_i == s_q.cmp[0] |=> s_q.flag[0])
        else $error("timer match set no flag");
    a_hso_toggle: assert property (
        ce_i && mode_of(s_q.mode[2]) == cacc_pkg::M_HSO && s_q.mode[2][6] && cnt_new_i &&
        counter_i == s_q.cmp[2] |=> s_q.pin[2] != $past(s_q.pin[2]))
        else $error("toggle mode match did not toggle");
    a_hso_hold: assert property (
        mode_of(s_q.mode[2]) == cacc_pkg::M_HSO && !s_q.mode[2][6] |=> s_q.pin[2] == $past(s_q.pin[2]))
        else $error("toggle pin moved with comparator off");
    a_pwm_off: assert property (
        ce_i && s_q.mode[0][1] && !s_q.mode[0][2] && !s_q.mode[0][6] |=> !s_q.pin[0])
        else $error("pwm pin high with comparator off");
    a_freq_step: assert property (
        ce_i && mode_of(s_q.mode[2]) == cacc_pkg::M_FREQ && s_q.mode[2][6] && cnt_new_i &&
        counter_i[7:0] == s_q.cmp[2][7:0] && !sfr_req_i.wr
        |=> s_q.cmp[2][7:0] == 8'($past(s_q.cmp[2][7:0]) + $past(s_q.cmp[2][15:8])))
        else $error("frequency step not added");
    a_intermediate_overflow_flag_set: assert property (
        ce_i && ovf_n |=> s_q.ovf)
        else $error("intermediate overflow not flagged");

endmodule

// [counter_array_capture_compare_tb_top.sv]
// counter_array_capture_compare_tb_top: register-level tests of the modules
// assumes: the bench plays counter and software, cacc_pin_model the pins
`timescale 1ns/1ns
module counter_array_capture_compare_tb_top;
    logic                          sys_clk_i;
    logic                          reset_i;
    logic [15:0]                   counter_i;  // timebase value
    logic                          cnt_new_i;  // counter step strobe
    cacc_pkg::cacc_req_s           req;        // register request
    logic [7:0]                    rdata;
    logic [cacc_pkg::NUM_MOD-1:0]  pin_in, pin_out, pin_oe_n, flag, irq, level;
    logic                          ovf_irq;
    int                            error_cnt;
    int                            num_checks;

    cacc_top cacc_top_inst (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(1'b1), .counter_i(counter_i),
        .cnt_new_i(cnt_new_i), .sfr_req_i(req), .sfr_rdata_o(rdata), .module_pin_i(pin_in),
        .module_pin_o(pin_out), .module_pin_oe_n_o(pin_oe_n), .module_event_flag_o(flag),
        .module_irq_o(irq), .overflow_irq_o(ovf_irq));

    cacc_pin_model cacc_pin_model_inst (
        .sys_clk_i(sys_clk_i), .level_i(level), .pin_o_i(pin_out), .pin_oe_n_i(pin_oe_n),
        .pin_wire_o(pin_in));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [3:0] ad(input int m, input logic [3:0] o);
        return 4'(m) * cacc_pkg::MOD_STRIDE + o;
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: signal %b, wanted %b", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, taken at the following edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        req <= '0;
        // let the taking edge settle before a caller looks at outputs
        #1;
    endtask

    // read strobe; data is settled just after the taking edge
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        req <= '0;
        #1 chk_val(rdata, exp);
    endtask

    // one counter step; results are visible after the evaluating edge
    task automatic tick(input logic [15:0] c);
        @(posedge sys_clk_i);
        counter_i <= c;
        cnt_new_i <= 1'b1;
        @(posedge sys_clk_i);
        cnt_new_i <= 1'b0;
        #1;
    endtask

    // new level on module 1 pin, then wait out model hold plus synchroniser
    task automatic edge_step(input logic lvl, input logic [15:0] c);
        @(posedge sys_clk_i);
        level[1]  <= lvl;
        counter_i <= c;
        repeat (7) @(posedge sys_clk_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset_i = 1'b1;
        counter_i = 16'h0000;
        cnt_new_i = 1'b0;
        req = '0;
        level = '0;
        error_cnt = 0;
        num_checks = 0;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        // reset values and an unmapped address
        for (int m = 0; m < cacc_pkg::NUM_MOD; m++) begin
            rd_chk(ad(m, cacc_pkg::A_MODE), cacc_pkg::MODE_RST);
            chk_pin(pin_oe_n[m], 1'b1);
        end
        rd_chk(cacc_pkg::A_PWMCFG, 8'h00);
        rd_chk(4'h3, 8'h00);
        // software timer on module 0, byte order side effects
        wr(ad(0, cacc_pkg::A_MODE), 8'h49);
        wr(ad(0, cacc_pkg::A_CMPL), 8'h10);
        rd_chk(ad(0, cacc_pkg::A_MODE), 8'h09);
        wr(ad(0, cacc_pkg::A_CMPH), 8'h00);
        rd_chk(ad(0, cacc_pkg::A_MODE), 8'h49);
        tick(16'h000F);
        chk_pin(flag[0], 1'b0);
        tick(16'h0010);
        chk_pin(flag[0], 1'b1);
        chk_pin(irq[0], 1'b1);
        tick(16'h0011);
        chk_pin(flag[0], 1'b1);
        wr(cacc_pkg::A_FLAGS, 8'h06);
        chk_pin(flag[0], 1'b0);
        chk_pin(irq[0], 1'b0);
        // capture on module 1 for each edge code
        for (int k = 1; k < 4; k++) begin
            wr(ad(1, cacc_pkg::A_MODE), {2'b00, 2'(k), 4'h0});
            edge_step(1'b1, 16'h1200 + 16'(k));
            chk_pin(flag[1], k[1]);
            if (k[1]) rd_chk(ad(1, cacc_pkg::A_CMPL), 8'(k));
            if (k[1]) rd_chk(ad(1, cacc_pkg::A_CMPH), 8'h12);
            wr(cacc_pkg::A_FLAGS, 8'h00);
            edge_step(1'b0, 16'h3400 + 16'(k));
            chk_pin(flag[1], k[0]);
            if (k[0]) rd_chk(ad(1, cacc_pkg::A_CMPH), 8'h34);
            wr(cacc_pkg::A_FLAGS, 8'h00);
        end
        // high-speed output on module 2
        wr(ad(2, cacc_pkg::A_MODE), 8'h4C);
        wr(ad(2, cacc_pkg::A_CMPL), 8'h20);
        wr(ad(2, cacc_pkg::A_CMPH), 8'h00);
        tick(16'h0020);
        chk_pin(pin_out[2], 1'b1);
        chk_pin(flag[2], 1'b1);
        chk_pin(pin_oe_n[2], 1'b0);
        wr(ad(2, cacc_pkg::A_CMPL), 8'h20);
        tick(16'h0020);
        chk_pin(pin_out[2], 1'b1);
        // frequency output on module 2
        wr(ad(2, cacc_pkg::A_MODE), 8'h46);
        wr(ad(2, cacc_pkg::A_CMPL), 8'h10);
        wr(ad(2, cacc_pkg::A_CMPH), 8'h20);
        tick(16'h0710);
        chk_pin(pin_out[2], 1'b0);
        rd_chk(ad(2, cacc_pkg::A_CMPL), 8'h30);
        tick(16'h0730);
        chk_pin(pin_out[2], 1'b1);
        // 8-bit pwm on module 0 with overflow interrupt
        wr(cacc_pkg::A_PWMCFG, 8'h20);
        wr(ad(0, cacc_pkg::A_MODE), 8'h42);
        wr(ad(0, cacc_pkg::A_CMPL), 8'h80);
        wr(ad(0, cacc_pkg::A_CMPH), 8'h40);
        tick(16'h0180);
        chk_pin(pin_out[0], 1'b1);
        tick(16'h0200);
        chk_pin(pin_out[0], 1'b0);
        chk_pin(ovf_irq, 1'b1);
        rd_chk(ad(0, cacc_pkg::A_CMPL), 8'h40);
        wr(cacc_pkg::A_PWMCFG, 8'h20);
        chk_pin(ovf_irq, 1'b0);
        wr(ad(0, cacc_pkg::A_CMPL), 8'h40);
        tick(16'h0240);
        chk_pin(pin_out[0], 1'b0);
        // 16-bit pwm with match flag on module 1
        wr(ad(1, cacc_pkg::A_MODE), 8'hCA);
        wr(ad(1, cacc_pkg::A_CMPL), 8'h00);
        wr(ad(1, cacc_pkg::A_CMPH), 8'h30);
        tick(16'h3000);
        chk_pin(pin_out[1], 1'b1);
        chk_pin(flag[1], 1'b1);
        tick(16'h0000);
        chk_pin(pin_out[1], 1'b0);
        // reload view, then 9-bit pwm reload on module 0
        wr(cacc_pkg::A_PWMCFG, 8'h80);
        wr(ad(0, cacc_pkg::A_CMPL), 8'h55);
        rd_chk(ad(0, cacc_pkg::A_CMPL), 8'h55);
        wr(cacc_pkg::A_PWMCFG, 8'h01);
        rd_chk(ad(0, cacc_pkg::A_CMPL), 8'h40);
        wr(ad(0, cacc_pkg::A_MODE), 8'h42);
        tick(16'h0200);
        rd_chk(ad(0, cacc_pkg::A_CMPL), 8'h55);
        tick(16'h0455);
        chk_pin(pin_out[0], 1'b1);
        // frequency output with a zero step and match flag on module 2
        wr(cacc_pkg::A_FLAGS, 8'h00);
        wr(ad(2, cacc_pkg::A_MODE), 8'h4E);
        wr(ad(2, cacc_pkg::A_CMPL), 8'h60);
        wr(ad(2, cacc_pkg::A_CMPH), 8'h00);
        tick(16'h0160);
        chk_pin(pin_out[2], 1'b0);
        chk_pin(flag[2], 1'b0);
        rd_chk(ad(2, cacc_pkg::A_CMPL), 8'h60);
        tick(16'h0060);
        chk_pin(pin_out[2], 1'b1);
        chk_pin(flag[2], 1'b1);
        test_done();
    end

    // hang guard, far beyond the few hundred cycles the tests take
    initial begin
        #(3000 * 100);
        error_cnt++;
        $display("unexpected at %0t: run did not finish", $time);
        test_done();
    end
endmodule
